// ---- logic/tms_sequencer.sv ----
// Operating-state and measurement-mode sequencer with APB registers
`timescale 1ns/100ps
`default_nettype none
// Contract
// R01: Reset leaves device asleep yet programmable
// R02: Clearing sleep starts in programmed state
// R03: Low three state bits; 011b is measure
// R04: Setup state: config access, no results
// R05: Measure state: results, no config access
// R06: Leaving measure aborts, clears results, status
// R07: State field 000b leaves state unchanged
// R08: Four modes chosen by selection field
// R09: Writes act after transfer completes
// R10: Pause follows conversion in repeating modes
// R11: Pause in 8us steps up to 2040us
// R12: Free-running repeats while start bit set
// R13: Start wakes device from power-down
// R14: Ready low during conversion, high after
// R15: Time field sets timed conversion period
// R16: Store three channels and temperature
// R17: Single-shot runs once, clears start bit
// R18: Trigger fall starts when start set
// R19: Trigger edges ignored during pause
// R20: Bounded mode stops at counted edge
// R21: Bounded length recorded when enabled
// R22: Host reads results during the pause
// R23: Aborted conversions leave no results
// R24: Trigger pin synchronised before edge detect
module tms_sequencer
  import tms_pkg::*;
#(
  parameter int unsigned P_CONV_BASE_CYC = CONV_BASE_CYC,
  parameter int unsigned P_PAUSE_STEP_CYC = PAUSE_STEP_CYC
)
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_trigger_pin,
  input wire tms_sample_t i_sample,
  output logic o_ready,
  output logic o_analog_on
);
  // ***************************
  // Declarations
  // ***************************
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_PAUSE} tms_fsm_t;
  tms_fsm_t fsm_ff;
  tms_fsm_t nxt_fsm;
  tms_mode_t mode;
  tms_sample_t result_ff;
  logic [2:0] dos_ff;
  logic sleep_ff;
  logic start_ff;
  logic [7:0] cfg1_ff;
  logic [7:0] cfg2_ff;
  logic [7:0] cfg3_ff;
  logic [7:0] pause_ff;
  logic [7:0] edges_ff;
  logic [LEN_W-1:0] meas_len_ff;
  logic [LEN_W-1:0] run_len_ff;
  logic [7:0] edge_cnt_ff;
  logic new_ff;
  logic meas_q_ff;
  logic meas_st;
  logic leave_meas;
  logic wr_acc;
  logic wr_state;
  logic set_start;
  logic rd_setup;
  logic trig_fall;
  logic tmr_last;
  logic tmr_load;
  logic [31:0] tmr_value;
  logic [31:0] conv_cyc;
  logic [31:0] pause_cyc;
  logic go;
  logic conv_end;
  logic abort;
  logic last_edge;
  logic [7:0] stop_edge;
  logic [31:0] rd_word;

  // ***************************
  // Register access decode
  // ***************************
  function automatic tms_class_t reg_class(input logic [7:0] addr);
    tms_class_t cls;
    unique case (addr)
      OFS_STATE, OFS_PAUSE, OFS_EDGES, OFS_STATUS: cls = CL_CTRL;
      OFS_CFG1, OFS_CFG2, OFS_CFG3: cls = CL_CFG;
      OFS_MEAS_LEN, OFS_RES_TEMP, OFS_RES_CH1, OFS_RES_CH2, OFS_RES_CH3: cls = CL_RES;
      default: cls = CL_NONE;
    endcase
    return cls;
  endfunction

  function automatic logic access_ok(input logic [7:0] addr, input logic meas);
    tms_class_t cls;
    cls = reg_class(addr);
    return (cls == CL_CTRL) || ((cls == CL_CFG) && !meas) || ((cls == CL_RES) && meas); // R04 R05
  endfunction

  assign meas_st = (dos_ff == DOS_MEAS); // R03
  assign mode = tms_mode_t'(cfg3_ff[CFG3_MODE_LSB +: 2]); // R08
  assign leave_meas = meas_q_ff && !meas_st;
  assign wr_acc = i_psel && i_penable && i_pwrite && access_ok(i_paddr, meas_st); // R09
  assign wr_state = wr_acc && (i_paddr == OFS_STATE);
  assign set_start = wr_state && i_pwdata[SC_START_BIT];
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !access_ok(i_paddr, meas_st);

  // ***************************
  // State control register
  // ***************************
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      dos_ff <= DOS_RST; // R01
      sleep_ff <= 1'b1; // R01
      start_ff <= 1'b0;
    end
    else
    begin
      if (conv_end && (mode == MODE_SINGLE))
        start_ff <= 1'b0; // R17
      if (wr_state)
      begin
        if (i_pwdata[2:0] == DOS_CFG || i_pwdata[2:0] == DOS_MEAS)
          dos_ff <= i_pwdata[2:0]; // R07
        sleep_ff <= i_pwdata[SC_SLEEP_BIT]; // R02
        start_ff <= i_pwdata[SC_START_BIT];
      end
    end
  end

  // ***************************
  // Configuration and control words
  // ***************************
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cfg1_ff <= CFG_RST;
      cfg2_ff <= CFG_RST;
      cfg3_ff <= CFG_RST;
      pause_ff <= CFG_RST;
      edges_ff <= CFG_RST;
    end
    else if (wr_acc)
    begin
      unique case (i_paddr)
        OFS_CFG1: cfg1_ff <= i_pwdata[7:0]; // R04
        OFS_CFG2: cfg2_ff <= i_pwdata[7:0];
        OFS_CFG3: cfg3_ff <= i_pwdata[7:0];
        OFS_PAUSE: pause_ff <= i_pwdata[7:0];
        OFS_EDGES: edges_ff <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ***************************
  // Read data
  // ***************************
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (i_paddr)
      OFS_STATE: rd_word[7:0] = {start_ff, sleep_ff, 3'h0, dos_ff};
      OFS_CFG1: rd_word[7:0] = cfg1_ff;
      OFS_CFG2: rd_word[7:0] = cfg2_ff;
      OFS_CFG3: rd_word[7:0] = cfg3_ff;
      OFS_PAUSE: rd_word[7:0] = pause_ff;
      OFS_EDGES: rd_word[7:0] = edges_ff;
      OFS_STATUS:
      begin
        rd_word[ST_READY_BIT] = o_ready;
        rd_word[ST_BUSY_BIT] = (fsm_ff != ST_IDLE);
        rd_word[ST_PAUSE_BIT] = (fsm_ff == ST_PAUSE);
        rd_word[ST_NEW_BIT] = new_ff;
      end
      OFS_MEAS_LEN: rd_word[LEN_W-1:0] = meas_len_ff;
      OFS_RES_TEMP: rd_word[RES_W-1:0] = result_ff.temp;
      OFS_RES_CH1: rd_word[RES_W-1:0] = result_ff.ch1;
      OFS_RES_CH2: rd_word[RES_W-1:0] = result_ff.ch2;
      OFS_RES_CH3: rd_word[RES_W-1:0] = result_ff.ch3;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Captured in the setup phase so the access phase sees a stable word
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_prdata <= 32'h0000_0000;
    else if (rd_setup)
      o_prdata <= access_ok(i_paddr, meas_st) ? rd_word : 32'h0000_0000; // R04 R05
  end

  // ***************************
  // Trigger pin and timer
  // ***************************
  tms_fall_detect u_trig
  (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_pin(i_trigger_pin), // R24
    .o_fall(trig_fall)
  );

  assign conv_cyc = 32'(P_CONV_BASE_CYC) << cfg1_ff[CFG1_TIME_LSB +: 4]; // R15
  assign pause_cyc = 32'(pause_ff) * 32'(P_PAUSE_STEP_CYC); // R11
  assign tmr_load = go || (conv_end && pause_ff != 8'h00);
  assign tmr_value = go ? conv_cyc : pause_cyc;

  tms_down_timer #(.W(32)) u_tmr
  (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_load(tmr_load),
    .i_value(tmr_value),
    .o_last(tmr_last)
  );

  // ***************************
  // Measurement sequencing
  // ***************************
  always_comb
  begin
    unique case (mode)
      MODE_FREE, MODE_SINGLE: go = 1'b1; // R12
      MODE_EDGE_TRIG, MODE_EDGE_BOUND: go = trig_fall; // R18
    endcase
    go = go && (fsm_ff == ST_IDLE) && meas_st && start_ff;
  end

  assign stop_edge = (edges_ff < 8'h02) ? 8'h02 : edges_ff;
  assign last_edge = trig_fall && ((edge_cnt_ff + 8'h01) >= stop_edge); // R20
  assign abort = (fsm_ff != ST_IDLE) && (!meas_st || !start_ff); // R23
  assign conv_end = (fsm_ff == ST_CONV) && meas_st && start_ff
    && ((mode == MODE_EDGE_BOUND) ? last_edge : tmr_last);

  always_comb
  begin
    nxt_fsm = fsm_ff;
    unique case (fsm_ff)
      ST_IDLE:
        if (go)
          nxt_fsm = ST_CONV;
      ST_CONV:
        if (abort)
          nxt_fsm = ST_IDLE; // R06
        else if (conv_end && mode != MODE_SINGLE && pause_ff != 8'h00)
          nxt_fsm = ST_PAUSE; // R10
        else if (conv_end)
          nxt_fsm = ST_IDLE;
      ST_PAUSE:
        if (abort || tmr_last)
          nxt_fsm = ST_IDLE; // R19
      default: nxt_fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      fsm_ff <= ST_IDLE;
    else
      fsm_ff <= nxt_fsm;
  end

  // Edge counter and bounded-length counter
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      edge_cnt_ff <= 8'h00;
      run_len_ff <= '0;
    end
    else if (go)
    begin
      edge_cnt_ff <= 8'h01;
      run_len_ff <= LEN_W'(1);
    end
    else if (fsm_ff == ST_CONV)
    begin
      if (trig_fall && edge_cnt_ff != 8'hFF)
        edge_cnt_ff <= edge_cnt_ff + 8'h01;
      if (run_len_ff != '1)
        run_len_ff <= run_len_ff + LEN_W'(1);
    end
  end

  // ***************************
  // Results and status
  // ***************************
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      result_ff <= '0;
      meas_len_ff <= '0;
      new_ff <= 1'b0;
      meas_q_ff <= 1'b0;
    end
    else
    begin
      meas_q_ff <= meas_st;
      if (leave_meas)
      begin
        result_ff <= '0; // R06
        meas_len_ff <= '0;
        new_ff <= 1'b0;
      end
      else if (conv_end)
      begin
        result_ff <= i_sample; // R16
        new_ff <= 1'b1;
        if (mode == MODE_EDGE_BOUND && cfg2_ff[CFG2_TM_BIT])
          meas_len_ff <= run_len_ff; // R21
      end
      else if (rd_setup && i_paddr == OFS_STATUS)
        new_ff <= 1'b0;
    end
  end

  // ***************************
  // Ready pin and analog power
  // ***************************
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_ready <= 1'b1;
      o_analog_on <= 1'b0; // R01
    end
    else
    begin
      if (go)
        o_ready <= 1'b0; // R14
      else if (conv_end || abort)
        o_ready <= 1'b1; // R14
      o_analog_on <= !sleep_ff || go || (nxt_fsm != ST_IDLE); // R02 R13
    end
  end

  // ***************************
  // Assertions
  // ***************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  AST_READY_CONV: // R14
    assert property (fsm_ff == ST_CONV |-> !o_ready) else $error("ready high during conversion");
  AST_RESULT_STORE: // R16
    assert property (conv_end |=> result_ff == $past(i_sample) && new_ff) else $error("results not stored");
  AST_SINGLE_CLEAR: // R17
    assert property (conv_end && mode == MODE_SINGLE && !set_start |=> !start_ff && fsm_ff == ST_IDLE)
      else $error("single shot did not stop");
  AST_LEAVE_CLEAR: // R06
    assert property (leave_meas |-> ##1 (result_ff == '0 && !new_ff && meas_len_ff == '0) ##1 fsm_ff == ST_IDLE)
      else $error("leaving measure kept results");
  AST_NO_CONV_CFG: // R04
    assert property (!meas_st && !$past(meas_st) |-> fsm_ff == ST_IDLE) else $error("conversion in setup state");
  AST_PAUSE_IGNORE: // R19
    assert property (fsm_ff == ST_PAUSE && trig_fall && !tmr_last && !abort |=> fsm_ff == ST_PAUSE)
      else $error("edge during pause acted");
  AST_NOP: // R07
    assert property (wr_state && i_pwdata[2:0] == DOS_NOP |=> $stable(dos_ff)) else $error("state changed by no-op");
  AST_DENY_CFG: // R05
    assert property (i_psel && i_penable && i_pwrite && i_paddr == OFS_CFG1 && meas_st |=> $stable(cfg1_ff))
      else $error("config written in measure state");
  AST_WAKE: // R13
    assert property (fsm_ff == ST_CONV |-> o_analog_on) else $error("converting while powered down");
  AST_FREE_GO: // R12
    assert property (fsm_ff == ST_IDLE && mode == MODE_FREE && start_ff && meas_st |=> fsm_ff == ST_CONV ##0 !o_ready)
      else $error("free running did not restart");
  AST_BOUND_STOP: // R20
    assert property (mode == MODE_EDGE_BOUND && fsm_ff == ST_CONV && last_edge && !abort |=> fsm_ff != ST_CONV && o_ready)
      else $error("bounded conversion did not stop");
  // Cycles spent so far in the current pause
  logic [31:0] pause_run_ff;
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      pause_run_ff <= 32'h0000_0000;
    else if (fsm_ff == ST_PAUSE)
      pause_run_ff <= pause_run_ff + 32'h0000_0001;
    else
      pause_run_ff <= 32'h0000_0000;
  end

  AST_PAUSE_LEN: // R10
    assert property (fsm_ff == ST_PAUSE && tmr_last && !abort |-> pause_run_ff == pause_cyc - 32'h0000_0001)
      else $error("pause length wrong");
endmodule // tms_sequencer
`default_nettype wire

// ---- logic/tms_pkg.sv ----
// Constants and carrier types of the measurement sequencer
`default_nettype none
package tms_pkg;
  // ***************************
  // Register offsets
  // ***************************
  localparam logic [7:0] OFS_STATE = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CFG2 = 8'h08;
  localparam logic [7:0] OFS_CFG3 = 8'h0C;
  localparam logic [7:0] OFS_PAUSE = 8'h10;
  localparam logic [7:0] OFS_EDGES = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MEAS_LEN = 8'h1C;
  localparam logic [7:0] OFS_RES_TEMP = 8'h20;
  localparam logic [7:0] OFS_RES_CH1 = 8'h24;
  localparam logic [7:0] OFS_RES_CH2 = 8'h28;
  localparam logic [7:0] OFS_RES_CH3 = 8'h2C;
  // ***************************
  // Field layout and reset values
  // ***************************
  localparam logic [2:0] DOS_NOP = 3'h0;
  localparam logic [2:0] DOS_CFG = 3'h2;
  localparam logic [2:0] DOS_MEAS = 3'h3;
  localparam int SC_SLEEP_BIT = 6;
  localparam int SC_START_BIT = 7;
  localparam int CFG1_TIME_LSB = 0;
  localparam int CFG2_TM_BIT = 3;
  localparam int CFG3_MODE_LSB = 6;
  localparam int ST_READY_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_PAUSE_BIT = 2;
  localparam int ST_NEW_BIT = 3;
  localparam logic [2:0] DOS_RST = DOS_CFG;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int RES_W = 16;
  localparam int LEN_W = 24;
  // ***************************
  // Timing
  // ***************************
  localparam int CLK_MHZ = 50;
  localparam int PAUSE_STEP_US = 8;
  localparam int PAUSE_STEP_CYC = PAUSE_STEP_US * CLK_MHZ;
  localparam int CONV_BASE_US = 1000;
  localparam int CONV_BASE_CYC = CONV_BASE_US * CLK_MHZ;
  // ***************************
  // Types
  // ***************************
  typedef enum logic [1:0] {MODE_FREE, MODE_SINGLE, MODE_EDGE_TRIG, MODE_EDGE_BOUND} tms_mode_t;
  typedef enum logic [1:0] {CL_CTRL, CL_CFG, CL_RES, CL_NONE} tms_class_t;
  typedef struct packed {
    logic [RES_W-1:0] temp;
    logic [RES_W-1:0] ch3;
    logic [RES_W-1:0] ch2;
    logic [RES_W-1:0] ch1;
  } tms_sample_t;
endpackage
`default_nettype wire

// ---- logic/tms_fall_detect.sv ----
// Two-stage synchroniser with falling-edge pulse
`timescale 1ns/100ps
`default_nettype none
module tms_fall_detect
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
      o_fall <= 1'b0;
    end
    else
    begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      o_fall <= last_ff & ~sync_ff;
    end
  end
endmodule // tms_fall_detect
`default_nettype wire

// ---- logic/tms_down_timer.sv ----
// Loadable down-counter flagging its last cycle
`timescale 1ns/100ps
`default_nettype none
module tms_down_timer
#(
  parameter int W = 32
)
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [W-1:0] i_value,
  output logic o_last
);
  logic [W-1:0] count_ff;
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      count_ff <= '0;
    else if (i_load)
      count_ff <= i_value;
    else if (count_ff != '0)
      count_ff <= count_ff - W'(1);
  end
  assign o_last = (count_ff == W'(1));
endmodule // tms_down_timer
`default_nettype wire

// ---- bench/tms_host_model.sv ----
// Host side APB requester model for the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module tms_host_model
(
  input wire logic i_core_clk,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // One whole transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= addr;
    o_pwdata <= wdata;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    do
      @(posedge i_core_clk);
    while (i_pready !== 1'b1);
    rdata = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released data lines do not keep their last value
    o_pwdata <= ~wdata;
  endtask
endmodule // tms_host_model
`default_nettype wire

// ---- bench/tms_sequencer_tb.sv ----
// Self-checking bench for the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module tms_sequencer_tb;
  import tms_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trig = 1'b1;
  tms_sample_t sample = 64'h4444_3333_2222_1111;
  logic psel, penable, pwrite, pready, pslverr, ready, analog_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int mismatches = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  tms_sequencer #(.P_CONV_BASE_CYC(8), .P_PAUSE_STEP_CYC(4)) tms_sequencer_inst (
    .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_trigger_pin(trig), .i_sample(sample), .o_ready(ready), .o_analog_on(analog_on));
  tms_host_model tms_host_model_inst (
    .i_core_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
  // ***************************
  // Shared tasks
  // ***************************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    tms_host_model_inst.xfer(1'b1, a, d, r, e);
  endtask
  // Read value carries the error flag above the data
  task automatic rd(input logic [7:0] a, output logic [32:0] v);
    logic [31:0] r;
    logic e;
    tms_host_model_inst.xfer(1'b0, a, 32'h0, r, e);
    v = {e, r};
  endtask
  // Counts falling edges until ready shows the level or the limit runs out
  task automatic wait_ready(input logic v, input int lim, output int n);
    n = 1;
    @(negedge clk);
    while (ready !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  // Trigger low for half of a 160 ns link period
  task automatic pulse;
    @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    trig <= 1'b1;
  endtask
  // ***************************
  // Scenarios
  // ***************************
  task automatic s_setup;
    logic [32:0] v;
    check(33'({ready, analog_on}), 33'h2);
    rd(OFS_STATE, v);
    check(v, 33'h42);
    rd(OFS_RES_CH1, v);
    check(v, 33'h1_0000_0000);
    wr(OFS_CFG1, 32'h1);
    wr(OFS_PAUSE, 32'h2);
    wr(OFS_EDGES, 32'h3);
    wr(OFS_CFG2, 32'h8);
    wr(OFS_CFG3, 32'h40);
    rd(OFS_CFG3, v);
    check(v, 33'h40);
  endtask
  task automatic s_single;
    logic [32:0] v;
    int n;
    wr(OFS_STATE, 32'h3);
    rd(OFS_STATE, v);
    check(v, 33'h3);
    check(33'(analog_on), 33'h1);
    rd(OFS_CFG1, v);
    check(v, 33'h1_0000_0000);
    wr(OFS_CFG1, 32'hF);
    wr(OFS_STATE, 32'h83);
    wait_ready(1'b0, 20, n);
    wait_ready(1'b1, 100, n);
    check(33'(n), 33'd16);
    rd(OFS_STATE, v);
    check(v, 33'h3);
    rd(OFS_RES_CH1, v);
    check(v, 33'h1111);
    rd(OFS_RES_TEMP, v);
    check(v, 33'h4444);
    rd(OFS_STATUS, v);
    check(v, 33'h9);
    wr(OFS_STATE, 32'h80);
    wait_ready(1'b0, 20, n);
    check(33'(n < 20), 33'h1);
    wait_ready(1'b1, 100, n);
    rd(OFS_STATE, v);
    check(v, 33'h3);
    wait_ready(1'b0, 40, n);
    check(33'(n), 33'd40);
  endtask
  task automatic s_abort;
    logic [32:0] v;
    int n;
    wr(OFS_STATE, 32'h80);
    wait_ready(1'b0, 20, n);
    wr(OFS_STATE, 32'h2);
    rd(OFS_STATUS, v);
    check(v, 33'h1);
    wr(OFS_CFG3, 32'h80);
    check(33'(ready), 33'h1);
    wr(OFS_STATE, 32'h3);
    rd(OFS_RES_CH1, v);
    check(v, 33'h0);
  endtask
  task automatic s_edge;
    int n;
    pulse;
    wait_ready(1'b0, 30, n);
    check(33'(n), 33'd30);
    wr(OFS_STATE, 32'h83);
    pulse;
    wait_ready(1'b0, 30, n);
    check(33'(n < 30), 33'h1);
    wait_ready(1'b1, 100, n);
    pulse;
    wait_ready(1'b0, 30, n);
    check(33'(n), 33'd30);
    wr(OFS_STATE, 32'h2);
  endtask
  task automatic s_free;
    logic [32:0] v;
    int n;
    wr(OFS_CFG3, 32'h0);
    wr(OFS_STATE, 32'h83);
    wait_ready(1'b0, 20, n);
    wait_ready(1'b1, 100, n);
    wait_ready(1'b0, 100, n);
    check(33'(n >= 8 && n <= 11), 33'h1);
    @(posedge clk);
    sample <= 64'h8888_7777_6666_5555;
    wr(OFS_STATE, 32'h3);
    rd(OFS_RES_CH1, v);
    check(v, 33'h1111);
    wait_ready(1'b0, 60, n);
    check(33'(n), 33'd60);
    wr(OFS_STATE, 32'h2);
  endtask
  task automatic s_bound;
    logic [32:0] v;
    int n;
    wr(OFS_CFG3, 32'hC0);
    wr(OFS_STATE, 32'hC3);
    pulse;
    repeat (35) @(posedge clk);
    check(33'({ready, analog_on}), 33'h1);
    pulse;
    repeat (35) @(posedge clk);
    check(33'(ready), 33'h0);
    pulse;
    wait_ready(1'b1, 10, n);
    check(33'(n < 10), 33'h1);
    rd(OFS_MEAS_LEN, v);
    check(33'(v >= 33'd78 && v <= 33'd82), 33'h1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_setup;
    s_single;
    s_abort;
    s_edge;
    s_free;
    s_bound;
    complete_run;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end
endmodule // tms_sequencer_tb
`default_nettype wire
